// file: bench/jesd_lane_sample_mapper_tb_top.sv
// Self-checking bench for the lane sample mapper
`timescale 1ns/10ps
module jesd_lane_sample_mapper_tb_top
    import lane_map_pkg::*;
;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [FMT_W-1:0] link_format_select = '0;
    logic frameValid = 1'b0;
    logic [S15_W-1:0] chan_a_inphase [QUAD], chan_a_quadrature [QUAD], chan_b_inphase [QUAD];
    logic [S15_W-1:0] chan_b_quadrature [QUAD], singleInphase [QUAD], singleQuadrature [QUAD];
    logic [QUAD-1:0] chan_a_i_flag, chan_a_q_flag, chan_b_i_flag, chan_b_q_flag, single_i_flag, single_q_flag;
    logic [S12_W-1:0] rawSample [RAW_N];
    logic [LANE_W-1:0] side_a_lane [LANES], side_b_lane [LANES], expA [LANES], expB [LANES];
    logic laneValid, formatError, expValid, expErr;
    logic [LANES-1:0] sideAActive, sideBActive, expMaskA, expMaskB;
    logic [2:0] octetsPerFrame, expOct;
    logic [S12_W-1:0] rxSample [8];
    int n_mismatch = 0;
    int tests_run = 0;

    jesd_lane_sample_mapper u_dut (
        .mclk, .reset_n, .link_format_select, .frameValid,
        .chan_a_inphase, .chan_a_quadrature, .chan_b_inphase, .chan_b_quadrature,
        .chan_a_i_flag, .chan_a_q_flag, .chan_b_i_flag, .chan_b_q_flag,
        .singleInphase, .singleQuadrature, .single_i_flag, .single_q_flag, .rawSample,
        .side_a_lane, .side_b_lane, .laneValid, .sideAActive, .sideBActive, .octetsPerFrame, .formatError
    );
    lane_rx_model u_rx (.laneValid, .side_a_lane, .rxSample);

    initial begin
        forever #2.5 mclk = ~mclk;
    end

    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic compare(input bit ok, input string what);
        tests_run++;
        if (!ok) begin
            n_mismatch++;
            $display("BAD at %0t: %s", $time, what);
        end
    endtask

    // Distinct sample and flag patterns per frame
    task automatic drive_inputs(input int v);
        for (int k = 0; k < QUAD; k++) begin
            chan_a_inphase[k] = 15'(32'h1101 * (k + 1) + v);
            chan_a_quadrature[k] = 15'(32'h2203 * (k + 1) + v);
            chan_b_inphase[k] = 15'(32'h3305 * (k + 1) + v);
            chan_b_quadrature[k] = 15'(32'h4407 * (k + 1) + v);
            singleInphase[k] = 15'(32'h5509 * (k + 1) + v);
            singleQuadrature[k] = 15'(32'h660B * (k + 1) + v);
        end
        chan_a_i_flag = 4'(v) ^ 4'h5;
        chan_a_q_flag = 4'(v) ^ 4'hA;
        chan_b_i_flag = 4'(v) ^ 4'h3;
        chan_b_q_flag = 4'(v) ^ 4'hC;
        single_i_flag = 4'(v) ^ 4'h6;
        single_q_flag = 4'(v) ^ 4'h9;
        for (int k = 0; k < RAW_N; k++) begin
            rawSample[k] = 12'(32'h9A3 * (k + 1) + v);
        end
    endtask

    function automatic logic [31:0] wd(input logic [S15_W-1:0] s, input logic f);
        return {s, f, 16'h0000};
    endfunction

    // Expected lane picture for a format code
    task automatic expect_fmt(input logic [FMT_W-1:0] f);
        int n;
        int s;
        int h;
        int idx;
        logic [47:0] grp;
        for (int k = 0; k < LANES; k++) begin
            expA[k] = '0;
            expB[k] = '0;
        end
        expOct = OCTETS_TWO;
        expErr = 1'b0;
        expValid = 1'b1;
        case (f)
            FMT_10, FMT_37, FMT_14, FMT_49, FMT_57, FMT_60, FMT_67: n = 1;
            FMT_11, FMT_47, FMT_15, FMT_55, FMT_58: n = 2;
            FMT_12, FMT_53, FMT_16: n = 4;
            FMT_21, FMT_36: n = -2;
            FMT_22, FMT_46: n = -4;
            FMT_23, FMT_38, FMT_61, FMT_64, FMT_69, FMT_71: n = -1;
            FMT_13, FMT_39, FMT_56, FMT_59, FMT_66, FMT_68: n = 5;
            FMT_19, FMT_42, FMT_20, FMT_43: n = 6;
            default: n = 0;
        endcase
        if (n > 0 && n < 5) begin
            for (int k = 0; k < n; k++) begin
                expA[k] = wd(chan_a_inphase[k], chan_a_i_flag[k]);
                expA[k + n] = wd(chan_a_quadrature[k], chan_a_q_flag[k]);
                expB[k] = wd(chan_b_inphase[k], chan_b_i_flag[k]);
                expB[k + n] = wd(chan_b_quadrature[k], chan_b_q_flag[k]);
            end
            n = 2 * n;
        end else if (n < 0) begin
            n = -n;
            for (int k = 0; k < n; k++) begin
                expA[k] = wd(singleInphase[k], single_i_flag[k]);
                expB[k] = wd(singleQuadrature[k], single_q_flag[k]);
            end
        end else if (n == 5) begin
            expA[0] = wd(chan_a_inphase[0], chan_a_i_flag[0]) | (wd(chan_a_quadrature[0], chan_a_q_flag[0]) >> 16);
            expB[0] = wd(chan_b_inphase[0], chan_b_i_flag[0]) | (wd(chan_b_quadrature[0], chan_b_q_flag[0]) >> 16);
            expOct = OCTETS_FOUR;
            n = 1;
        end else if (n == 6) begin
            for (int g = 0; g < 4; g++) begin
                s = g / 2;
                h = g % 2;
                for (int j = 0; j < 4; j++) begin
                    idx = (f == FMT_19 || f == FMT_42) ? 2 * (4 * h + j) + s : 8 * s + 4 * h + j;
                    grp[47 - 12 * j -: 12] = rawSample[idx];
                end
                for (int m = 0; m < 3; m++) begin
                    if (s == 0) begin
                        expA[3 * h + m] = {grp[47 - 16 * m -: 16], 16'h0000};
                    end else begin
                        expB[3 * h + m] = {grp[47 - 16 * m -: 16], 16'h0000};
                    end
                end
            end
        end else begin
            expValid = 1'b0;
            expErr = 1'b1;
        end
        expMaskA = 8'((1 << n) - 1);
        expMaskB = expMaskA;
    endtask

    task automatic check_outputs(input string what);
        for (int k = 0; k < LANES; k++) begin
            compare(side_a_lane[k] === expA[k] && side_b_lane[k] === expB[k], what);
        end
        compare(sideAActive === expMaskA && sideBActive === expMaskB, what);
        compare(laneValid === expValid && formatError === expErr, what);
        if (!expErr) begin
            compare(octetsPerFrame === expOct, what);
        end
    endtask

    // Frames back to back, each judged at the falling edge after the rising edge that takes it
    task automatic run_list(input logic [FMT_W-1:0] codes [$], input string what);
        foreach (codes[i]) begin
            drive_inputs(i * 7 + 1);
            link_format_select = codes[i];
            frameValid = 1'b1;
            expect_fmt(codes[i]);
            @(negedge mclk);
            check_outputs(what);
        end
    endtask

    task automatic test_reset;
        reset_n = 1'b0;
        frameValid = 1'b0;
        repeat (5) @(negedge mclk);
        expect_fmt(7'h7F);
        expErr = 1'b0;
        expOct = OCTETS_TWO;
        check_outputs("reset values");
        reset_n = 1'b1;
        $display("Test reset done");
    endtask

    task automatic test_dual;
        run_list('{FMT_10, FMT_37, FMT_11, FMT_47, FMT_12, FMT_53, FMT_14, FMT_49, FMT_57,
                   FMT_60, FMT_67, FMT_15, FMT_55, FMT_58, FMT_16}, "dual split");
        frameValid = 1'b0;
        expValid = 1'b0;
        @(negedge mclk);
        check_outputs("hold after frame");
        $display("Test dual done");
    endtask

    task automatic test_four_octet;
        run_list('{FMT_13, FMT_39, FMT_56, FMT_59, FMT_66, FMT_68}, "four octet");
        $display("Test four octet done");
    endtask

    task automatic test_single;
        run_list('{FMT_21, FMT_36, FMT_22, FMT_46, FMT_23, FMT_38, FMT_61, FMT_64,
                   FMT_69, FMT_71}, "single channel");
        $display("Test single done");
    endtask

    task automatic test_packed;
        logic [FMT_W-1:0] codes [4] = '{FMT_19, FMT_42, FMT_20, FMT_43};
        foreach (codes[i]) begin
            run_list('{codes[i]}, "packed lanes");
            for (int k = 0; k < 8; k++) begin
                compare(rxSample[k] === rawSample[(i < 2) ? 2 * k : k], "rebuilt order");
            end
        end
        $display("Test packed done");
    endtask

    task automatic test_bad_code;
        run_list('{FMT_23, 7'h00, 7'h18, 7'h7F, FMT_13}, "unsupported code");
        $display("Test bad code done");
    endtask

    initial begin
        repeat (100000) @(posedge mclk);
        n_mismatch++;
        $display("BAD at %0t: run limit reached", $time);
        complete_run();
    end

    initial begin
        drive_inputs(0);
        test_reset();
        test_dual();
        test_four_octet();
        test_single();
        test_packed();
        test_bad_code();
        test_reset();
        complete_run();
    end
endmodule

// file: bench/lane_rx_model.sv
// Receiver model rebuilding packed 12-bit samples from the side A lanes
`timescale 1ns/10ps
module lane_rx_model
    import lane_map_pkg::*;
(
    // Lane inputs
    input wire logic laneValid,
    input wire logic [LANE_W-1:0] side_a_lane [LANES],
    // Rebuilt samples, index 0 earliest
    output logic [S12_W-1:0] rxSample [8]
);
    logic [95:0] groupBits;

    // Two three-lane groups back to back, first lane first
    assign groupBits = {side_a_lane[0][31:16], side_a_lane[1][31:16], side_a_lane[2][31:16],
                        side_a_lane[3][31:16], side_a_lane[4][31:16], side_a_lane[5][31:16]};

    // Ascending sample order, pattern when no frame is valid
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            rxSample[k] = laneValid ? groupBits[95 - 12 * k -: 12] : 12'hFFF;
        end
    end
endmodule

// file: logic/jesd_lane_sample_mapper.sv
// Transport mapper placing converter samples on side A and side B lanes
`timescale 1ns/10ps
module jesd_lane_sample_mapper
    import lane_map_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Format selection and frame strobe
    input wire logic [FMT_W-1:0] link_format_select,
    input wire logic frameValid,
    // Dual channel 15-bit samples and flags
    input wire logic [S15_W-1:0] chan_a_inphase [QUAD],
    input wire logic [S15_W-1:0] chan_a_quadrature [QUAD],
    input wire logic [S15_W-1:0] chan_b_inphase [QUAD],
    input wire logic [S15_W-1:0] chan_b_quadrature [QUAD],
    input wire logic [QUAD-1:0] chan_a_i_flag,
    input wire logic [QUAD-1:0] chan_a_q_flag,
    input wire logic [QUAD-1:0] chan_b_i_flag,
    input wire logic [QUAD-1:0] chan_b_q_flag,
    // Single channel 15-bit samples and flags
    input wire logic [S15_W-1:0] singleInphase [QUAD],
    input wire logic [S15_W-1:0] singleQuadrature [QUAD],
    input wire logic [QUAD-1:0] single_i_flag,
    input wire logic [QUAD-1:0] single_q_flag,
    // Bypass 12-bit samples
    input wire logic [S12_W-1:0] rawSample [RAW_N],
    // Lane data, octet 0 in bits 31:24
    output logic [LANE_W-1:0] side_a_lane [LANES],
    output logic [LANE_W-1:0] side_b_lane [LANES],
    // Frame status
    output logic laneValid,
    output logic [LANES-1:0] sideAActive,
    output logic [LANES-1:0] sideBActive,
    output logic [2:0] octetsPerFrame,
    output logic formatError
);

    // Builds a 16-bit lane word from a sample and its flag
    function automatic logic [WORD_W-1:0] flagWord(input logic [S15_W-1:0] s, input logic f);
        flagWord = {s, f};
    endfunction

    layout_e layoutSel;
    logic [2:0] laneCount;
    logic [7:0] maskSel;
    logic [2:0] octetSel;
    logic [LANE_W-1:0] sideANext [LANES];
    logic [LANE_W-1:0] sideBNext [LANES];
    logic [LANE_W-1:0] sideAReg [LANES];
    logic [LANE_W-1:0] sideBReg [LANES];
    logic laneValidReg;
    logic [LANES-1:0] sideAActiveReg;
    logic [LANES-1:0] sideBActiveReg;
    logic [2:0] octetsReg;
    logic formatErrorReg;
    logic packDual;
    logic [3:0][S12_W-1:0] packIn [4];
    logic [2:0][WORD_W-1:0] packOut [4];

    // Format decode into a placement family and lane count
    always_comb begin
        layoutSel = LAY_NONE;
        laneCount = CNT_1;
        case (link_format_select)
            FMT_10, FMT_37, FMT_14, FMT_49, FMT_57, FMT_60, FMT_67: begin
                layoutSel = LAY_DUAL_SPLIT;
                laneCount = CNT_1;
            end
            FMT_11, FMT_47, FMT_15, FMT_55, FMT_58: begin
                layoutSel = LAY_DUAL_SPLIT;
                laneCount = CNT_2;
            end
            FMT_12, FMT_53, FMT_16: begin
                layoutSel = LAY_DUAL_SPLIT;
                laneCount = CNT_4;
            end
            FMT_13, FMT_39, FMT_56, FMT_59, FMT_66, FMT_68: begin
                layoutSel = LAY_DUAL_ONE;
            end
            FMT_19, FMT_42: begin
                layoutSel = LAY_PACK_SINGLE;
            end
            FMT_20, FMT_43: begin
                layoutSel = LAY_PACK_DUAL;
            end
            FMT_21, FMT_36: begin
                layoutSel = LAY_SINGLE;
                laneCount = CNT_2;
            end
            FMT_22, FMT_46: begin
                layoutSel = LAY_SINGLE;
                laneCount = CNT_4;
            end
            FMT_23, FMT_38, FMT_61, FMT_64, FMT_69, FMT_71: begin
                layoutSel = LAY_SINGLE;
                laneCount = CNT_1;
            end
            default: begin
                layoutSel = LAY_NONE;
                laneCount = CNT_1;
            end
        endcase
    end

    // Active lanes per side and octets per lane
    assign maskSel = (layoutSel == LAY_DUAL_SPLIT && laneCount == CNT_1) ? MASK_2 :
                     (layoutSel == LAY_DUAL_SPLIT && laneCount == CNT_2) ? MASK_4 :
                     (layoutSel == LAY_DUAL_SPLIT) ? MASK_8 :
                     (layoutSel == LAY_DUAL_ONE) ? MASK_1 :
                     (layoutSel == LAY_SINGLE && laneCount == CNT_1) ? MASK_1 :
                     (layoutSel == LAY_SINGLE && laneCount == CNT_2) ? MASK_2 :
                     (layoutSel == LAY_SINGLE) ? MASK_4 :
                     (layoutSel == LAY_NONE) ? MASK_NONE : MASK_6;
    assign octetSel = (layoutSel == LAY_DUAL_ONE) ? OCTETS_FOUR : OCTETS_TWO;
    assign packDual = (layoutSel == LAY_PACK_DUAL);

    // Sample groups for the four packers: g0 side A low, g1 side A high, g2 side B low, g3 side B high
    for (genvar g = 0; g < 4; g++) begin : gPack
        for (genvar j = 0; j < 4; j++) begin : gSel
            // Single: even samples on side A, odd on side B; dual: A in 0..7, B in 8..15
            assign packIn[g][j] = packDual ? rawSample[8 * (g / 2) + 4 * (g % 2) + j] :
                                  rawSample[8 * (g % 2) + 2 * j + (g / 2)];
        end
        pack_twelve uPack (
            .samples(packIn[g]),
            .laneWords(packOut[g])
        );
    end

    // Lane word placement
    always_comb begin
        for (int k = 0; k < LANES; k++) begin
            sideANext[k] = '0;
            sideBNext[k] = '0;
        end
        case (layoutSel)
            LAY_DUAL_SPLIT: begin
                // In-phase on the first half of the lanes, quadrature on the second half
                for (int k = 0; k < QUAD; k++) begin
                    if (k < int'(laneCount)) begin
                        sideANext[k] = {flagWord(chan_a_inphase[k], chan_a_i_flag[k]), 16'h0000};
                        sideANext[k + int'(laneCount)] =
                            {flagWord(chan_a_quadrature[k], chan_a_q_flag[k]), 16'h0000};
                        sideBNext[k] = {flagWord(chan_b_inphase[k], chan_b_i_flag[k]), 16'h0000};
                        sideBNext[k + int'(laneCount)] =
                            {flagWord(chan_b_quadrature[k], chan_b_q_flag[k]), 16'h0000};
                    end
                end
            end
            LAY_DUAL_ONE: begin
                sideANext[0] = {flagWord(chan_a_inphase[0], chan_a_i_flag[0]),
                                flagWord(chan_a_quadrature[0], chan_a_q_flag[0])};
                sideBNext[0] = {flagWord(chan_b_inphase[0], chan_b_i_flag[0]),
                                flagWord(chan_b_quadrature[0], chan_b_q_flag[0])};
            end
            LAY_SINGLE: begin
                for (int k = 0; k < QUAD; k++) begin
                    if (k < int'(laneCount)) begin
                        sideANext[k] = {flagWord(singleInphase[k], single_i_flag[k]), 16'h0000};
                        sideBNext[k] = {flagWord(singleQuadrature[k], single_q_flag[k]), 16'h0000};
                    end
                end
            end
            LAY_PACK_SINGLE, LAY_PACK_DUAL: begin
                for (int k = 0; k < 3; k++) begin
                    sideANext[k] = {packOut[0][k], 16'h0000};
                    sideANext[k + 3] = {packOut[1][k], 16'h0000};
                    sideBNext[k] = {packOut[2][k], 16'h0000};
                    sideBNext[k + 3] = {packOut[3][k], 16'h0000};
                end
            end
            default: begin
                for (int k = 0; k < LANES; k++) begin
                    sideANext[k] = '0;
                    sideBNext[k] = '0;
                end
            end
        endcase
    end

    // Output registers, loaded in each cycle with the frame strobe high; laneValid is loaded every cycle
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            for (int k = 0; k < LANES; k++) begin
                sideAReg[k] <= '0;
                sideBReg[k] <= '0;
            end
            laneValidReg <= 1'b0;
            sideAActiveReg <= MASK_NONE;
            sideBActiveReg <= MASK_NONE;
            octetsReg <= OCTETS_TWO;
            formatErrorReg <= 1'b0;
        end else begin
            laneValidReg <= frameValid && (layoutSel != LAY_NONE);
            if (frameValid) begin
                for (int k = 0; k < LANES; k++) begin
                    sideAReg[k] <= sideANext[k];
                    sideBReg[k] <= sideBNext[k];
                end
                sideAActiveReg <= maskSel;
                sideBActiveReg <= maskSel;
                octetsReg <= octetSel;
                formatErrorReg <= (layoutSel == LAY_NONE);
            end
        end
    end

    for (genvar k = 0; k < LANES; k++) begin : gOut
        assign side_a_lane[k] = sideAReg[k];
        assign side_b_lane[k] = sideBReg[k];
    end
    assign laneValid = laneValidReg;
    assign sideAActive = sideAActiveReg;
    assign sideBActive = sideBActiveReg;
    assign octetsPerFrame = octetsReg;
    assign formatError = formatErrorReg;

    // Checks on the lane placement one cycle after the frame strobe
    default clocking cbMap @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    fmt10_lane_map_a: assert property (
        frameValid && link_format_select == FMT_37 |=>
        side_a_lane[1][31:16] == {$past(chan_a_quadrature[0]), $past(chan_a_q_flag[0])} &&
        side_b_lane[0][31:16] == {$past(chan_b_inphase[0]), $past(chan_b_i_flag[0])} && sideAActive == MASK_2)
        else $error("format 10 lane map wrong");

    fmt11_lane_map_a: assert property (
        frameValid && link_format_select == FMT_11 |=>
        side_a_lane[2][31:16] == {$past(chan_a_quadrature[0]), $past(chan_a_q_flag[0])} &&
        side_b_lane[1][31:16] == {$past(chan_b_inphase[1]), $past(chan_b_i_flag[1])})
        else $error("format 11 lane map wrong");

    fmt12_lane_map_a: assert property (
        frameValid && link_format_select == FMT_12 |=>
        side_a_lane[7][31:16] == {$past(chan_a_quadrature[3]), $past(chan_a_q_flag[3])} &&
        side_b_lane[3][31:16] == {$past(chan_b_inphase[3]), $past(chan_b_i_flag[3])} && laneValid)
        else $error("format 12 lane map wrong");

    fmt13_octet_map_a: assert property (
        frameValid && link_format_select == FMT_68 |=>
        side_a_lane[0][15:0] == {$past(chan_a_quadrature[0]), $past(chan_a_q_flag[0])} &&
        octetsPerFrame == OCTETS_FOUR && side_a_lane[1] == '0)
        else $error("format 13 octet map wrong");

    fmt16_lane_map_a: assert property (
        frameValid && link_format_select == FMT_16 |=>
        side_b_lane[4][31:16] == {$past(chan_b_quadrature[0]), $past(chan_b_q_flag[0])} && sideBActive == MASK_8)
        else $error("format 16 lane map wrong");

    fmt19_pack_map_a: assert property (
        frameValid && link_format_select == FMT_19 |=>
        side_a_lane[3][31:16] == {$past(rawSample[8]), $past(rawSample[10][11:8])} &&
        side_b_lane[2][31:16] == {$past(rawSample[5][3:0]), $past(rawSample[7])})
        else $error("format 19 packing wrong");

    fmt20_pack_map_a: assert property (
        frameValid && link_format_select == FMT_43 |=>
        side_b_lane[4][31:16] == {$past(rawSample[13][7:0]), $past(rawSample[14][11:4])} &&
        sideAActive == MASK_6)
        else $error("format 20 packing wrong");

    fmt22_lane_map_a: assert property (
        frameValid && link_format_select == FMT_22 |=>
        side_b_lane[3][31:16] == {$past(singleQuadrature[3]), $past(single_q_flag[3])} && side_a_lane[4] == '0)
        else $error("format 22 lane map wrong");

    fmt23_lane_map_a: assert property (
        frameValid && link_format_select == FMT_23 |=>
        side_a_lane[0][16] == $past(single_i_flag[0]) && sideBActive == MASK_1)
        else $error("format 23 lane map wrong");

    fmt14_lane_map_a: assert property (
        frameValid && link_format_select == FMT_49 |=>
        side_a_lane[1][31:16] == {$past(chan_a_quadrature[0]), $past(chan_a_q_flag[0])} &&
        side_b_lane[1][31:16] == {$past(chan_b_quadrature[0]), $past(chan_b_q_flag[0])} && side_a_lane[2] == '0)
        else $error("format 14 lane map wrong");

    fmt15_lane_map_a: assert property (
        frameValid && link_format_select == FMT_58 |=>
        side_a_lane[1][31:16] == {$past(chan_a_inphase[1]), $past(chan_a_i_flag[1])} &&
        side_b_lane[3][31:16] == {$past(chan_b_quadrature[1]), $past(chan_b_q_flag[1])} && sideBActive == MASK_4)
        else $error("format 15 lane map wrong");

    fmt21_lane_map_a: assert property (
        frameValid && link_format_select == FMT_36 |=>
        side_a_lane[1][31:16] == {$past(singleInphase[1]), $past(single_i_flag[1])} &&
        side_b_lane[0][31:16] == {$past(singleQuadrature[0]), $past(single_q_flag[0])} && sideAActive == MASK_2)
        else $error("format 21 lane map wrong");

    flag_bit_pos_a: assert property (
        frameValid && link_format_select == FMT_10 |=>
        side_b_lane[0][16] == $past(chan_b_i_flag[0]) && side_b_lane[0][15:0] == 16'h0000)
        else $error("flag bit misplaced");

    bad_format_flag_a: assert property (
        frameValid && layoutSel == LAY_NONE |=> formatError && !laneValid && sideAActive == MASK_NONE)
        else $error("unsupported format not flagged");

endmodule

// file: logic/lane_map_pkg.sv
// Constants and types shared by the lane sample mapper
package lane_map_pkg;

    // Link format codes, primary and alias values
    localparam logic [6:0] FMT_10 = 7'h0A;
    localparam logic [6:0] FMT_37 = 7'h25;
    localparam logic [6:0] FMT_11 = 7'h0B;
    localparam logic [6:0] FMT_47 = 7'h2F;
    localparam logic [6:0] FMT_12 = 7'h0C;
    localparam logic [6:0] FMT_53 = 7'h35;
    localparam logic [6:0] FMT_13 = 7'h0D;
    localparam logic [6:0] FMT_39 = 7'h27;
    localparam logic [6:0] FMT_56 = 7'h38;
    localparam logic [6:0] FMT_59 = 7'h3B;
    localparam logic [6:0] FMT_66 = 7'h42;
    localparam logic [6:0] FMT_68 = 7'h44;
    localparam logic [6:0] FMT_14 = 7'h0E;
    localparam logic [6:0] FMT_49 = 7'h31;
    localparam logic [6:0] FMT_57 = 7'h39;
    localparam logic [6:0] FMT_60 = 7'h3C;
    localparam logic [6:0] FMT_67 = 7'h43;
    localparam logic [6:0] FMT_15 = 7'h0F;
    localparam logic [6:0] FMT_55 = 7'h37;
    localparam logic [6:0] FMT_58 = 7'h3A;
    localparam logic [6:0] FMT_16 = 7'h10;
    localparam logic [6:0] FMT_19 = 7'h13;
    localparam logic [6:0] FMT_42 = 7'h2A;
    localparam logic [6:0] FMT_20 = 7'h14;
    localparam logic [6:0] FMT_43 = 7'h2B;
    localparam logic [6:0] FMT_21 = 7'h15;
    localparam logic [6:0] FMT_36 = 7'h24;
    localparam logic [6:0] FMT_22 = 7'h16;
    localparam logic [6:0] FMT_46 = 7'h2E;
    localparam logic [6:0] FMT_23 = 7'h17;
    localparam logic [6:0] FMT_38 = 7'h26;
    localparam logic [6:0] FMT_61 = 7'h3D;
    localparam logic [6:0] FMT_64 = 7'h40;
    localparam logic [6:0] FMT_69 = 7'h45;
    localparam logic [6:0] FMT_71 = 7'h47;

    // Widths
    localparam int FMT_W = 7;
    localparam int S15_W = 15;
    localparam int S12_W = 12;
    localparam int WORD_W = 16;
    localparam int LANE_W = 32;
    localparam int LANES = 8;
    localparam int QUAD = 4;
    localparam int RAW_N = 16;

    // Octets carried per lane per frame
    localparam logic [2:0] OCTETS_TWO = 3'h2;
    localparam logic [2:0] OCTETS_FOUR = 3'h4;

    // Lanes per side in each layout family
    localparam logic [2:0] CNT_1 = 3'h1;
    localparam logic [2:0] CNT_2 = 3'h2;
    localparam logic [2:0] CNT_4 = 3'h4;
    localparam logic [7:0] MASK_NONE = 8'h00;
    localparam logic [7:0] MASK_1 = 8'h01;
    localparam logic [7:0] MASK_2 = 8'h03;
    localparam logic [7:0] MASK_4 = 8'h0F;
    localparam logic [7:0] MASK_6 = 8'h3F;
    localparam logic [7:0] MASK_8 = 8'hFF;

    // Lane placement families
    typedef enum logic [2:0] {
        LAY_NONE,
        LAY_DUAL_SPLIT,
        LAY_DUAL_ONE,
        LAY_SINGLE,
        LAY_PACK_SINGLE,
        LAY_PACK_DUAL
    } layout_e;

endpackage

// file: logic/pack_twelve.sv
// Packs four 12-bit samples back to back into three 16-bit lane words
`timescale 1ns/10ps
module pack_twelve
    import lane_map_pkg::*;
(
    // Samples, index 0 earliest
    input wire logic [3:0][S12_W-1:0] samples,
    // Lane words, index 0 first lane of the group
    output logic [2:0][WORD_W-1:0] laneWords
);

    assign laneWords[0] = {samples[0], samples[1][11:8]};
    assign laneWords[1] = {samples[1][7:0], samples[2][11:4]};
    assign laneWords[2] = {samples[2][3:0], samples[3]};

endmodule
